// File: rtl/tws_master.sv
// Purpose: Two-wire bus master that reads and writes 16-bit sensor
//          registers on orders given over AXI4-Lite
// Assumes: Single 100 MHz clock, external pull-up on the data line
// Notes:   One transfer per order; status shows busy, done and nack
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module tws_master #(
   parameter int QTR_CYCLES = tws_pkg::TWS_QTR_CYCLES
) (
   // System
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Two-wire link
   output logic             serial_clock,
   input  wire logic        serial_data_line_i,
   output logic             serial_data_line_o,
   output logic             serial_data_line_oe,
   // Device identity straps
   output logic             id_select_high_pin,
   output logic             id_select_low_pin
);
   import tws_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic          aw_have;
      logic [3:0]    aw_addr;
      logic          w_have;
      logic [31:0]   w_data;
      logic [3:0]    w_strb;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          op_read;
      logic          op_byte;
      logic [1:0]    id_sel;
      logic [7:0]    ptr;
      logic [15:0]   wword;
      logic [15:0]   rword;
      logic          busy;
      logic          done;
      logic          nack;
      tws_state_type st;
      tws_stage_type stage;
      logic [15:0]   qcnt;
      logic [1:0]    ph;
      logic [3:0]    bitn;
      logic [7:0]    shreg;
      logic          scl;
      logic          sda_oe;
      logic          sda_out;
      logic          sda_s1;
      logic          sda_s2;
   } tws_regs_type;

   tws_regs_type r_q;
   tws_regs_type r_d;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // write ID lookup
   function automatic logic [7:0] id_of(input logic [1:0] sel);
      case (sel)
         2'b00:   id_of = TWS_ID_00;
         2'b01:   id_of = TWS_ID_01;
         2'b10:   id_of = TWS_ID_10;
         default: id_of = TWS_ID_11;
      endcase
   endfunction : id_of

   // Byte sent at each transmit stage
   function automatic logic [7:0] tx_byte(input tws_regs_type r,
                                          input tws_stage_type g);
      case (g)
         TWS_G_AW:  tx_byte = id_of(r.id_sel);
         TWS_G_PTR: tx_byte = r.ptr;
         TWS_G_D0:  tx_byte = r.wword[15:8];
         TWS_G_D1:  tx_byte = r.wword[7:0];
         TWS_G_AR:  tx_byte = id_of(r.id_sel) | 8'h01;
         default:   tx_byte = 8'hff;
      endcase
   endfunction : tx_byte

   function automatic logic is_rx(input tws_stage_type g);
      is_rx = (g == TWS_G_R0) || (g == TWS_G_R1);
   endfunction : is_rx

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      logic tick;
      logic [31:0] status;
      logic last_rx;
      tick    = 1'b0;
      status  = '0;
      last_rx = 1'b0;
      r_d = r_q;

      // Two-flop synchroniser for the data line
      r_d.sda_s1 = serial_data_line_i;
      r_d.sda_s2 = r_q.sda_s1;

      // ---- AXI write channel capture
      if (s_axi_awvalid && r_q.awready) begin
         r_d.aw_have = 1'b1;
         r_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_q.wready) begin
         r_d.w_have = 1'b1;
         r_d.w_data = s_axi_wdata;
         r_d.w_strb = s_axi_wstrb;
      end
      if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end

      // ---- Register write once address and data are both held
      if (r_q.aw_have && r_q.w_have && !r_q.bvalid) begin
         r_d.aw_have = 1'b0;
         r_d.w_have  = 1'b0;
         r_d.bvalid  = 1'b1;
         r_d.bresp   = TWS_RESP_OKAY;
         // Full offset decode: unaligned offsets answer with an error
         case (r_q.aw_addr)
            TWS_OFS_CTRL: begin
               // New order only when idle and full low half written
               if (r_q.w_data[TWS_CTRL_GO] && r_q.w_strb[0] &&
                   r_q.w_strb[1] && !r_q.busy) begin
                  r_d.op_read = r_q.w_data[TWS_CTRL_READ];
                  r_d.op_byte = r_q.w_data[TWS_CTRL_BYTE];
                  r_d.id_sel  = r_q.w_data[TWS_CTRL_ID_LO +: 2];
                  r_d.ptr     = r_q.w_data[TWS_CTRL_PTR_LO +: 8];
                  r_d.busy    = 1'b1;
                  r_d.done    = 1'b0;
                  r_d.nack    = 1'b0;
                  r_d.st      = TWS_S_START;
                  r_d.stage   = TWS_G_AW;
                  r_d.ph      = 2'b00;
                  r_d.qcnt    = '0;
               end
            end
            TWS_OFS_WDATA: begin
               if (r_q.w_strb[0]) begin
                  r_d.wword[7:0] = r_q.w_data[7:0];
               end
               if (r_q.w_strb[1]) begin
                  r_d.wword[15:8] = r_q.w_data[15:8];
               end
            end
            TWS_OFS_STATUS: ;
            TWS_OFS_RDATA:  ;
            default: r_d.bresp = TWS_RESP_SLVERR;
         endcase
      end

      // ---- AXI read channel
      if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r_q.arready) begin
         status[TWS_STAT_BUSY] = r_q.busy;
         status[TWS_STAT_DONE] = r_q.done;
         status[TWS_STAT_NACK] = r_q.nack;
         r_d.rvalid = 1'b1;
         r_d.rresp  = TWS_RESP_OKAY;
         case (s_axi_araddr)
            TWS_OFS_CTRL: r_d.rdata = {16'h0000,
               r_q.ptr, 2'b00, r_q.id_sel, 1'b0, r_q.op_byte,
               r_q.op_read, 1'b0};
            TWS_OFS_WDATA:  r_d.rdata = {16'h0000, r_q.wword};
            TWS_OFS_STATUS: r_d.rdata = status;
            TWS_OFS_RDATA:  r_d.rdata = {16'h0000, r_q.rword};
            default: begin
               r_d.rdata = '0;
               r_d.rresp = TWS_RESP_SLVERR;
            end
         endcase
      end

      // ---- Quarter-bit divider: master makes the clock
      // master clock pulses
      if (r_q.st != TWS_S_IDLE) begin
         if (r_q.qcnt == 16'(QTR_CYCLES - 1)) begin
            r_d.qcnt = '0;
            tick     = 1'b1;
         end else begin
            r_d.qcnt = r_q.qcnt + 16'h0001;
         end
      end

      // ---- Bit engine, four quarters per bit
      if (tick) begin
         r_d.ph = r_q.ph + 2'b01;
         case (r_q.st)
            TWS_S_START: begin
               case (r_q.ph)
                  // Release data; clock is low on a repeated start, still high after idle
                  2'b00: r_d.sda_oe = 1'b0;
                  2'b01: r_d.scl = 1'b1;
                  2'b10: r_d.sda_oe = 1'b1;
                  default: begin
                     r_d.scl   = 1'b0;
                     r_d.st    = TWS_S_BYTE;
                     r_d.bitn  = '0;
                     r_d.shreg = tx_byte(r_q, r_q.stage);
                  end
               endcase
            end
            TWS_S_BYTE: begin
               last_rx = r_q.op_byte || (r_q.stage == TWS_G_R1);
               case (r_q.ph)
                  2'b00: begin
                     if (r_q.bitn == 4'd8) begin
                        r_d.sda_oe = is_rx(r_q.stage) && !last_rx;
                     end else if (is_rx(r_q.stage)) begin
                        r_d.sda_oe = 1'b0;
                     end else begin
                        r_d.sda_oe = !r_q.shreg[7];
                     end
                  end
                  2'b01: r_d.scl = 1'b1;
                  2'b10: begin
                     if (r_q.bitn != 4'd8) begin
                        r_d.rword = {r_q.rword[14:0], r_q.sda_s2};
                        r_d.shreg = {r_q.shreg[6:0], 1'b0};
                     end else if (!is_rx(r_q.stage) && r_q.sda_s2) begin
                        r_d.nack = 1'b1;
                     end
                  end
                  default: begin
                     r_d.scl  = 1'b0;
                     r_d.bitn = r_q.bitn + 4'd1;
                     if (r_q.bitn == 4'd8) begin
                        r_d.bitn  = '0;
                        r_d.st    = TWS_S_BYTE;
                        if (r_d.nack) begin
                           r_d.st = TWS_S_STOP;
                        end else begin
                           case (r_q.stage)
                              TWS_G_AW:  r_d.stage = TWS_G_PTR;
                              TWS_G_PTR: begin
                                 if (r_q.op_read) begin
                                    r_d.stage = TWS_G_AR;
                                    r_d.st    = TWS_S_START;
                                 end else begin
                                    r_d.stage = TWS_G_D0;
                                 end
                              end
                              TWS_G_D0: begin
                                 if (r_q.op_byte) begin
                                    r_d.st = TWS_S_STOP;
                                 end else begin
                                    r_d.stage = TWS_G_D1;
                                 end
                              end
                              TWS_G_AR: r_d.stage = TWS_G_R0;
                              TWS_G_R0: begin
                                 if (r_q.op_byte) begin
                                    r_d.st = TWS_S_STOP;
                                 end else begin
                                    r_d.stage = TWS_G_R1;
                                 end
                              end
                              default: r_d.st = TWS_S_STOP;
                           endcase
                           r_d.shreg = tx_byte(r_q, r_d.stage);
                        end
                     end
                  end
               endcase
            end
            TWS_S_STOP: begin
               case (r_q.ph)
                  2'b00: r_d.sda_oe = 1'b1;
                  2'b01: r_d.scl = 1'b1;
                  2'b10: r_d.sda_oe = 1'b0;
                  default: begin
                     r_d.st   = TWS_S_IDLE;
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
               endcase
            end
            default: r_d.ph = 2'b00;
         endcase
      end

      // Ready outputs track the holding flags
      r_d.awready = !r_d.aw_have;
      r_d.wready  = !r_d.w_have;
      r_d.arready = !r_d.rvalid;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q         <= '0;
         r_q.st      <= TWS_S_IDLE;
         r_q.stage   <= TWS_G_AW;
         r_q.scl     <= 1'b1;
         r_q.sda_s1  <= 1'b1;
         r_q.sda_s2  <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // All straight from the state flops
   assign s_axi_awready       = r_q.awready;
   assign s_axi_wready        = r_q.wready;
   assign s_axi_bvalid        = r_q.bvalid;
   assign s_axi_bresp         = r_q.bresp;
   assign s_axi_arready       = r_q.arready;
   assign s_axi_rvalid        = r_q.rvalid;
   assign s_axi_rdata         = r_q.rdata;
   assign s_axi_rresp         = r_q.rresp;
   assign serial_clock        = r_q.scl;
   assign serial_data_line_o  = r_q.sda_out;   // Always low when enabled
   assign serial_data_line_oe = r_q.sda_oe;
   assign id_select_high_pin  = r_q.id_sel[1];
   assign id_select_low_pin   = r_q.id_sel[0];

endmodule : tws_master

// File: shared/tws_pkg.sv
// Purpose: Constants for the two-wire register master controller
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register port
// Notes:   Shared by the controller and the verification side
package tws_pkg;

   // ****************************************************************
   // Controller register map (byte addresses)
   // ****************************************************************
   localparam logic [3:0] TWS_OFS_CTRL   = 4'h0;
   localparam logic [3:0] TWS_OFS_WDATA  = 4'h4;
   localparam logic [3:0] TWS_OFS_STATUS = 4'h8;
   localparam logic [3:0] TWS_OFS_RDATA  = 4'hc;

   // Control field positions
   localparam int TWS_CTRL_GO    = 0;
   localparam int TWS_CTRL_READ  = 1;
   localparam int TWS_CTRL_BYTE  = 2;
   localparam int TWS_CTRL_ID_LO = 4;
   localparam int TWS_CTRL_PTR_LO = 8;

   // Status field positions
   localparam int TWS_STAT_BUSY = 0;
   localparam int TWS_STAT_DONE = 1;
   localparam int TWS_STAT_NACK = 2;

   // AXI responses
   localparam logic [1:0] TWS_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TWS_RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Device side constants
   // ****************************************************************
   localparam logic [7:0] TWS_ID_00 = 8'h90;
   localparam logic [7:0] TWS_ID_01 = 8'h98;
   localparam logic [7:0] TWS_ID_10 = 8'hb0;
   localparam logic [7:0] TWS_ID_11 = 8'hb8;
   localparam logic [7:0] TWS_REG_LOWER_BYTE_ACCESS = 8'hf0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int TWS_CLK_MHZ       = 100;
   localparam int TWS_SCL_PERIOD_NS = 10000;
   localparam int TWS_QTR_CYCLES    =
      (TWS_CLK_MHZ * TWS_SCL_PERIOD_NS) / 4000;

   // Engine states and byte stages
   typedef enum logic [1:0] {
      TWS_S_IDLE  = 2'b00,
      TWS_S_START = 2'b01,
      TWS_S_BYTE  = 2'b10,
      TWS_S_STOP  = 2'b11
   } tws_state_type;

   typedef enum logic [2:0] {
      TWS_G_AW  = 3'b000,
      TWS_G_PTR = 3'b001,
      TWS_G_D0  = 3'b010,
      TWS_G_D1  = 3'b011,
      TWS_G_AR  = 3'b100,
      TWS_G_R0  = 3'b101,
      TWS_G_R1  = 3'b110
   } tws_stage_type;

endpackage : tws_pkg

// File: dv/tws_master_monitor.sv
// Purpose: Protocol checks on the two-wire master ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ps

module tws_master_monitor #(
   parameter int QTR_CYCLES = 250
) (
   // System
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Link
   input wire logic        serial_clock,
   input wire logic        serial_data_line_o,
   input wire logic        serial_data_line_oe,
   input wire logic        id_select_high_pin,
   input wire logic        id_select_low_pin
);
   localparam int QWIN    = QTR_CYCLES + 1;
   localparam int LOW_LEN = 2 * QTR_CYCLES;
   logic [15:0] low_cnt_q;

   // Length of the current low phase of the bus clock
   always_ff @(posedge aclk) begin
      low_cnt_q <= (!aresetn || serial_clock) ? 16'h0 : low_cnt_q + 16'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   a_start_shape: assert property ($rose(serial_data_line_oe) &&
      serial_clock |-> ##[1:QWIN] (serial_data_line_oe && !serial_clock))
      else $error("start not followed by clock low");
   a_stop_idle: assert property ($fell(serial_data_line_oe) &&
      serial_clock |=> serial_clock [*8]) else $error("bus not idle");
   a_low_period: assert property ($rose(serial_clock) |->
      low_cnt_q == 16'(LOW_LEN)) else $error("clock low phase length");
   a_straps_steady: assert property (!serial_clock |->
      $stable({id_select_high_pin, id_select_low_pin}))
      else $error("straps moved in a frame");
   a_open_drain: assert property (serial_data_line_oe |->
      !serial_data_line_o) else $error("data line driven high");

   // Main scenarios
   c_start: cover property ($rose(serial_data_line_oe) && serial_clock);
   c_stop: cover property ($fell(serial_data_line_oe) && serial_clock);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : tws_master_monitor

bind tws_master tws_master_monitor #(.QTR_CYCLES(QTR_CYCLES)) mon_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .serial_clock(serial_clock),
   .serial_data_line_o(serial_data_line_o),
   .serial_data_line_oe(serial_data_line_oe),
   .id_select_high_pin(id_select_high_pin),
   .id_select_low_pin(id_select_low_pin));

// File: dv/tws_sensor_model.sv
// Purpose: Behavioural sensor register slave on the two-wire bus
// Assumes: Clock and data lines resolved by the bench
// Notes:   Changes its data pull only while the clock is low
`timescale 1ns/1ps

module tws_sensor_model (
   // Bus lines
   input  wire logic serial_clock,
   input  wire logic serial_data_line,
   // Identity straps
   input  wire logic id_select_high_pin,
   input  wire logic id_select_low_pin,
   // High pulls the data line low
   output logic      pull_low
);
   logic [15:0] regs [0:255];
   logic [15:0] tx;
   logic [7:0]  sh, ptr, hw, bw_hi, bw_tgt, id, last_addr;
   logic        act, rd, half;
   int          cnt, nb;

   initial begin
      pull_low = 1'b0;
      act = 1'b0;
      for (int i = 0; i < 256; i++) regs[i] = {i[7:0], ~i[7:0]};
   end

   always @* begin
      case ({id_select_high_pin, id_select_low_pin})
         2'b00: id = 8'h90;
         2'b01: id = 8'h98;
         2'b10: id = 8'hb0;
         default: id = 8'hb8;
      endcase
   end

   always @(negedge serial_data_line) if (serial_clock === 1'b1) begin
      act = 1'b1;
      rd = 1'b0;
      half = 1'b0;
      cnt = 0;
      nb = 0;
      pull_low = 1'b0;
   end

   always @(posedge serial_data_line) if (serial_clock === 1'b1) begin
      act = 1'b0;
      pull_low = 1'b0;
   end

   // Sample bits and acknowledge slots
   always @(posedge serial_clock) if (act === 1'b1) begin
      if (cnt < 8) begin
         sh = {sh[6:0], serial_data_line};
         cnt++;
      end else begin
         cnt = 0;
         if (rd && nb > 1 && serial_data_line) act = 1'b0;
      end
   end

   // data moves only while the clock is low
   always @(negedge serial_clock) if (act === 1'b1) begin
      if (cnt < 8) begin
         pull_low = rd && nb > 0 && !tx[15];
         if (rd && nb > 0) tx = {tx[14:0], 1'b0};
      // release for the answer, step per word
      end else if (rd && nb > 0) begin
         pull_low = 1'b0;
         if (half) begin
            ptr++;
            tx = regs[ptr];
         end
         half = !half;
      end else if (nb == 0) begin
         if (sh[7:1] != id[7:1]) act = 1'b0;
         else begin
            rd = sh[0];
            pull_low = 1'b1;
            last_addr = sh;
            tx = (ptr == 8'hf0) ? {regs[bw_tgt][7:0], 8'h00} : regs[ptr];
         end
      end else if (nb == 1) begin
         ptr = sh;
         if (sh != 8'hf0) bw_tgt = sh;
         pull_low = 1'b1;
      end else begin
         pull_low = 1'b1;
         if (ptr == 8'hf0) regs[bw_tgt] = {bw_hi, sh};
         else if (!half) begin
            hw = sh;
            bw_hi = sh;
            half = 1'b1;
         end else begin
            regs[ptr] = {hw, sh};
            ptr++;
            half = 1'b0;
         end
      end
      if (cnt == 8) nb++;
   end
endmodule : tws_sensor_model

// File: dv/tws_master_tb.sv
// Purpose: Self-checking bench for the two-wire master
// Assumes: Shortened quarter count, bench drives the register bus
// Notes:   Sensor model stands on the link side
`timescale 1ns/1ps

module tws_master_tb;
   import tws_pkg::*;
   localparam logic [7:0] IDS [4] = '{8'h90, 8'h98, 8'hb0, 8'hb8};
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, flip;
   logic        scl, sda_o, sda_oe, sel_hi, sel_lo, pull;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   int          fails, comparisons, cycles;
   wire         sda = !(sda_oe | pull);

   tws_master #(.QTR_CYCLES(4)) dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serial_clock(scl), .serial_data_line_i(sda),
      .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
      .id_select_high_pin(sel_hi), .id_select_low_pin(sel_lo));

   tws_sensor_model model_u (.serial_clock(scl), .serial_data_line(sda),
      .id_select_high_pin(sel_hi ^ flip), .id_select_low_pin(sel_lo),
      .pull_low(pull));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         summarize();
      end
   end

   task automatic check(input string nm, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                            output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // Let an edge pass before the next request may raise bready
      @(posedge aclk);
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      // Let an edge pass before the next request may raise rready
      @(posedge aclk);
   endtask : axi_read

   task automatic run_order(input logic rd, bt, input logic [1:0] id,
      input logic [7:0] p, input logic [15:0] wd, output logic [31:0] st);
      logic [1:0] r;
      axi_write(TWS_OFS_WDATA, {16'h0, wd}, r);
      axi_write(TWS_OFS_CTRL, {16'h0, p, 2'b00, id, 1'b0, bt, rd, 1'b1}, r);
      axi_read(TWS_OFS_STATUS, st, r);
      check("busy", 32'h1, 32'(st[TWS_STAT_BUSY]));
      do axi_read(TWS_OFS_STATUS, st, r); while (st[TWS_STAT_DONE] !== 1'b1);
      check("bus idle", 32'h3, {30'h0, scl, sda});
      check("strap pins", 32'(id), {30'h0, sel_hi, sel_lo});
   endtask : run_order

   task automatic t_ids();
      logic [31:0] st, d;
      logic [1:0]  r;
      logic [7:0]  p;
      for (int i = 0; i < 4; i++) begin
         p = 8'h10 + 8'(i);
         run_order(1'b0, 1'b0, 2'(i), p, 16'hc3a0 + 16'(i), st);
         check("write nack", 32'h0, 32'(st[TWS_STAT_NACK]));
         check("write id", 32'(IDS[i]), 32'(model_u.last_addr));
         check("word", 32'hc3a0 + 32'(i), 32'(model_u.regs[p]));
         check("write ptr", 32'(p) + 32'h1, 32'(model_u.ptr));
         run_order(1'b1, 1'b0, 2'(i), p, 16'h0, st);
         axi_read(TWS_OFS_RDATA, d, r);
         check("read word", 32'hc3a0 + 32'(i), {16'h0, d[15:0]});
         check("read id", 32'(IDS[i] | 8'h01), 32'(model_u.last_addr));
         check("read ptr", 32'(p) + 32'h1, 32'(model_u.ptr));
      end
   endtask : t_ids

   task automatic t_bytes();
      logic [31:0] st, d;
      logic [1:0]  r;
      run_order(1'b0, 1'b1, 2'b01, 8'h20, 16'h5a00, st);
      check("half write", 32'h20df, 32'(model_u.regs[8'h20]));
      run_order(1'b0, 1'b1, 2'b01, 8'hf0, 16'h3c00, st);
      check("byte commit", 32'h5a3c, 32'(model_u.regs[8'h20]));
      run_order(1'b1, 1'b1, 2'b01, 8'h20, 16'h0, st);
      axi_read(TWS_OFS_RDATA, d, r);
      check("upper byte", 32'h5a, {24'h0, d[7:0]});
      run_order(1'b1, 1'b1, 2'b01, 8'hf0, 16'h0, st);
      axi_read(TWS_OFS_RDATA, d, r);
      check("lower byte", 32'h3c, {24'h0, d[7:0]});
   endtask : t_bytes

   task automatic t_nack();
      logic [31:0] st;
      flip <= 1'b1;
      run_order(1'b0, 1'b0, 2'b00, 8'h30, 16'h1234, st);
      check("nack flag", 32'h1, 32'(st[TWS_STAT_NACK]));
      check("untouched", 32'h30cf, 32'(model_u.regs[8'h30]));
      flip <= 1'b0;
   endtask : t_nack

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(TWS_OFS_STATUS, d, r);
      check("status reset", 32'h0, d);
      axi_read(4'h2, d, r);
      check("unmapped read", 32'(TWS_RESP_SLVERR), 32'(r));
      axi_write(4'h6, 32'h0, r);
      check("unmapped write", 32'(TWS_RESP_SLVERR), 32'(r));
      axi_read(TWS_OFS_CTRL, d, r);
      check("go reads zero", 32'h0, 32'(d[TWS_CTRL_GO]));
   endtask : t_regs

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, flip} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_ids();
      t_bytes();
      t_nack();
      summarize();
   end
endmodule : tws_master_tb
